// File: spi_ctrl_consts.vh
`ifndef SPI_CTRL_CONSTS_VH
`define SPI_CTRL_CONSTS_VH
// register byte addresses (one aligned word each)
`define ADDR_DATA 12'h000
`define ADDR_CTRL 12'h004
`define ADDR_CSR 12'h008
`define ADDR_WAKE 12'h00c
// control field positions
`define CTRL_IRQ_EN 7
`define CTRL_PIN_EN 6
`define CTRL_RATE_HALF 5
`define CTRL_MASTER 4
`define CTRL_IDLE_LVL 3
`define CTRL_PHASE 2
`define CTRL_RATE_HI 1
`define CTRL_RATE_LO 0
// status field positions
`define CSR_DONE 7
`define CSR_WRITE_COLLISION_FLAG 6
`define CSR_OVR 5
`define CSR_MASTER_FAULT_FLAG 4
`define CSR_SOD 2
`define CSR_SSM 1
`define CSR_SSI 0
// reset values
`define CTRL_RESET 8'h00
`define CSR_RESET 8'h00
// bits per transfer
`define XFER_BITS 4'h8
`endif

// File: spi_ctrl_status.v
// Summary of operation
// R1: all events share one gated interrupt output; the write collision flag does not drive IRQ here
// R2: done, fault, overrun wake wait; done wakes halt
// R3: irq enable gates done, fault, overrun requests
// R4: pin enable; cleared by master select fault
// R5: master select; cleared by select fault
// R6: idle level of serial clock
// R7: capture phase first or second edge
// R8: master clock divider 4 to 128
// R9: divider bits ignored in slave mode
// R10: done set at end; status then data clears
// R11: data writes ignored while done pending
// R12: collision flag on write during transfer
// R13: overrun when byte lands with done set
// R14: fault flag; status access then control write
// R15: reserved status bit written as zero
// R16: output disable kills data output pin
// R17: soft select replaces external select pin
// R18: soft select level zero selects slave
// R19: both ends use same polarity and phase
// R20: disable port before changing polarity
// R21: control status resets to zero
// R22: overrun keeps first byte, later lost
// R23: fault blocks setting enable and master
// R24: master data write starts one byte
// R25: eight bits, buffer loaded on last edge
//
// Our own choices: the address map and the APB register port.
`include "spi_ctrl_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module spi_ctrl_status (
    // clock and reset
    input wire CORE_CLK,
    input wire RST_B,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // cpu interrupt mask and power state
    input wire IRQ_MASK,
    output reg IRQ,
    output reg WAKE_WAIT,
    output reg WAKE_HALT,
    // serial clock pin
    input wire SCK_I,
    output reg SCK_O,
    output reg SCK_OE,
    // controller-out data pin
    input wire MOSI_I,
    output reg MOSI_O,
    output reg MOSI_OE,
    // peripheral-out data pin
    input wire MISO_I,
    output reg MISO_O,
    output reg MISO_OE,
    // slave select pin, input only
    input wire SS_B_I
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    reg [7:0] ctrl_q;
    reg done_q;
    reg write_collision_flag_q;
    reg ovr_q;
    reg master_fault_flag_q;
    reg sod_q;
    reg ssm_q;
    reg ssi_q;
    reg csr_seen_q;
    reg master_fault_flag_seen_q;
    reg [7:0] shift_q;
    reg [7:0] rxbuf_q;
    // receive bits gather apart from the launch register
    reg [7:0] rx_q;
    // phase 1 must not shift on its first leading edge
    reg tx_first_q;
    reg state_q;
    reg [3:0] bits_q;
    reg [6:0] div_q;
    reg sck_int_q, half_q;
    reg [2:0] sck_s_q, mosi_s_q, miso_s_q, ss_s_q;
    reg busy_rx_q;

    // three-stage pin synchronisers; compare stages 2 and 3 only
    reg sck_f_q, mosi_f_q, miso_f_q, ss_f_q;
    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            sck_s_q <= 3'h0;
            mosi_s_q <= 3'h0;
            miso_s_q <= 3'h0;
            ss_s_q <= 3'h7;
            sck_f_q <= 1'b0;
            mosi_f_q <= 1'b0;
            miso_f_q <= 1'b0;
            ss_f_q <= 1'b1;
        end else begin
            sck_s_q <= {sck_s_q[1:0], SCK_I};
            mosi_s_q <= {mosi_s_q[1:0], MOSI_I};
            miso_s_q <= {miso_s_q[1:0], MISO_I};
            ss_s_q <= {ss_s_q[1:0], SS_B_I};
            if (sck_s_q[1] == sck_s_q[2]) sck_f_q <= sck_s_q[2];
            if (mosi_s_q[1] == mosi_s_q[2]) mosi_f_q <= mosi_s_q[2];
            if (miso_s_q[1] == miso_s_q[2]) miso_f_q <= miso_s_q[2];
            if (ss_s_q[1] == ss_s_q[2]) ss_f_q <= ss_s_q[2];
        end
    end

    wire en = ctrl_q[`CTRL_PIN_EN];
    wire master = ctrl_q[`CTRL_MASTER];
    wire clock_idle_level = ctrl_q[`CTRL_IDLE_LVL];
    wire clock_capture_phase = ctrl_q[`CTRL_PHASE];
    wire sel_b = ssm_q ? ssi_q : ss_f_q; // R17 R18

    // half period of sck in core cycles, minus one
    function [6:0] half_div;
        input [2:0] code;
        begin
            case (code)
                3'b100: half_div = 7'd1; // R8
                3'b000: half_div = 7'd3;
                3'b001: half_div = 7'd7;
                3'b110: half_div = 7'd15;
                3'b010: half_div = 7'd31;
                3'b011: half_div = 7'd63;
                default: half_div = 7'd63;
            endcase
        end
    endfunction
    wire [6:0] half_lim = half_div({ctrl_q[`CTRL_RATE_HALF], ctrl_q[1:0]});

    // apb decode; one wait state
    // only the first access edge counts; the ready edge must not repeat a write
    wire acc = PSEL && PENABLE && !PREADY;
    wire wr = acc && PWRITE;
    wire rd = acc && !PWRITE;
    wire hit_data = PADDR == `ADDR_DATA;
    wire hit_ctrl = PADDR == `ADDR_CTRL;
    wire hit_csr = PADDR == `ADDR_CSR;
    wire hit_wake = PADDR == `ADDR_WAKE;
    wire mapped = hit_data | hit_ctrl | hit_csr | hit_wake;
    wire data_wr = wr && hit_data;
    wire data_rd = rd && hit_data;
    wire csr_acc = acc && hit_csr;
    wire ctrl_wr = wr && hit_ctrl;
    wire [7:0] csr_val = {done_q, write_collision_flag_q, ovr_q, master_fault_flag_q, 1'b0, sod_q, ssm_q, ssi_q};

    // slave-side edge tracking of synchronised sck
    reg sck_prev_q;
    wire sck_rise = sck_f_q && !sck_prev_q;
    wire sck_fall = !sck_f_q && sck_prev_q;
    // with clock_idle_level, leading edge is a fall; capture on leading when clock_capture_phase=0
    wire lead = clock_idle_level ? sck_fall : sck_rise;
    wire trail = clock_idle_level ? sck_rise : sck_fall;
    wire s_cap = (clock_capture_phase ? trail : lead) && en && !master && !sel_b; // R6 R7
    wire s_shf = (clock_capture_phase ? lead : trail) && en && !master && !sel_b;

    // master engine events
    wire m_tick = state_q == ST_RUN && div_q == half_lim; // R9
    wire m_cap = m_tick && (half_q == clock_capture_phase);
    wire m_shf = m_tick && (half_q != clock_capture_phase);
    wire rx_bit = master ? miso_f_q : mosi_f_q;
    wire cap = master ? m_cap : s_cap;
    wire shf = master ? m_shf : s_shf;
    wire last = cap && bits_q == `XFER_BITS - 4'h1; // R25
    wire busy = master ? (state_q == ST_RUN) : busy_rx_q;
    wire fault = en && master && !sel_b; // R14
    wire wr_ok = data_wr && !done_q && !busy; // R11

    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            ctrl_q <= `CTRL_RESET; // R21
            done_q <= 1'b0; // R21
            write_collision_flag_q <= 1'b0;
            ovr_q <= 1'b0;
            master_fault_flag_q <= 1'b0;
            sod_q <= 1'b0;
            ssm_q <= 1'b0;
            ssi_q <= 1'b0;
            rx_q <= 8'h00;
            tx_first_q <= 1'b1;
            csr_seen_q <= 1'b0;
            master_fault_flag_seen_q <= 1'b0;
            shift_q <= 8'h00;
            rxbuf_q <= 8'h00;
            state_q <= ST_IDLE;
            bits_q <= 4'h0;
            div_q <= 7'h00;
            half_q <= 1'b0;
            sck_int_q <= 1'b0;
            sck_prev_q <= 1'b0;
            busy_rx_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_f_q;
            // status access arms the done / collision clear
            if (csr_acc) csr_seen_q <= 1'b1;
            else if (data_wr || data_rd) csr_seen_q <= 1'b0;
            if (csr_acc && master_fault_flag_q) master_fault_flag_seen_q <= 1'b1;
            else if (ctrl_wr) master_fault_flag_seen_q <= 1'b0;
            if (wr && hit_csr) begin
                // reserved bit 3 ignored; software keeps it zero
                sod_q <= PWDATA[`CSR_SOD];
                ssm_q <= PWDATA[`CSR_SSM];
                ssi_q <= PWDATA[`CSR_SSI];
            end
            if (ctrl_wr) begin
                ctrl_q <= PWDATA[7:0];
                if (master_fault_flag_q && !master_fault_flag_seen_q) begin
                    ctrl_q[`CTRL_PIN_EN] <= PWDATA[`CTRL_PIN_EN] & en; // R23
                    ctrl_q[`CTRL_MASTER] <= PWDATA[`CTRL_MASTER] & master; // R23
                end
            end
            // clears first; hardware sets below win
            if (csr_seen_q && (data_wr || data_rd)) done_q <= 1'b0; // R10
            if (csr_seen_q && data_rd) write_collision_flag_q <= 1'b0;
            if (csr_acc && !PWRITE) ovr_q <= 1'b0; // R13
            if (master_fault_flag_seen_q && ctrl_wr) master_fault_flag_q <= 1'b0; // R14
            if (data_wr && busy) write_collision_flag_q <= 1'b1; // R12
            if (fault) begin
                master_fault_flag_q <= 1'b1; // R14
                ctrl_q[`CTRL_PIN_EN] <= 1'b0; // R4
                ctrl_q[`CTRL_MASTER] <= 1'b0; // R5
                state_q <= ST_IDLE;
            end
            // shift engine
            if (wr_ok) begin
                shift_q <= PWDATA[7:0];
                bits_q <= 4'h0;
                tx_first_q <= 1'b1;
                if (master && en && !fault) begin
                    state_q <= ST_RUN; // R24
                    div_q <= 7'h00;
                    half_q <= 1'b0;
                end
            end
            if (m_tick) begin
                div_q <= 7'h00;
                half_q <= ~half_q;
                sck_int_q <= ~sck_int_q;
            end else if (state_q == ST_RUN) begin
                div_q <= div_q + 7'h01;
            end
            if (s_cap || s_shf) busy_rx_q <= 1'b1;
            if (!master && sel_b) begin
                bits_q <= 4'h0;
                busy_rx_q <= 1'b0;
                tx_first_q <= 1'b1;
            end
            // capture and launch kept apart so data never moves on the sampling edge
            if (cap) begin
                rx_q <= {rx_q[6:0], rx_bit};
                bits_q <= bits_q + 4'h1;
            end
            if (shf) begin
                tx_first_q <= 1'b0;
                if (!(clock_capture_phase && tx_first_q)) shift_q <= {shift_q[6:0], 1'b0}; // R7
            end
            if (last) begin
                bits_q <= 4'h0;
                busy_rx_q <= 1'b0;
                done_q <= 1'b1; // R10
                // a byte landing with done still set is dropped
                if (done_q && !(csr_seen_q && (data_wr || data_rd))) begin
                    ovr_q <= 1'b1; // R13
                end else begin
                    rxbuf_q <= {rx_q[6:0], rx_bit}; // R22 R25
                end
                if (master) state_q <= ST_IDLE;
            end
            if (state_q == ST_IDLE && !m_tick) begin
                sck_int_q <= 1'b0;
                half_q <= 1'b0;
            end
        end
    end

    // output pins and apb answer, all registered
    wire drive_out = en && !sod_q; // R16
    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            IRQ <= 1'b0;
            WAKE_WAIT <= 1'b0;
            WAKE_HALT <= 1'b0;
            SCK_O <= 1'b0;
            SCK_OE <= 1'b0;
            MOSI_O <= 1'b0;
            MOSI_OE <= 1'b0;
            MISO_O <= 1'b0;
            MISO_OE <= 1'b0;
        end else begin
            // answer in the access cycle's next edge: one wait state
            PREADY <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
            PRDATA <= 32'h00000000;
            if (PSEL && !PWRITE) begin
                if (hit_data) PRDATA <= {24'h000000, rxbuf_q};
                if (hit_ctrl) PRDATA <= {24'h000000, ctrl_q};
                if (hit_csr) PRDATA <= {24'h000000, csr_val};
                if (hit_wake) PRDATA <= {30'h00000000, WAKE_HALT, WAKE_WAIT};
            end
            IRQ <= ctrl_q[`CTRL_IRQ_EN] && !IRQ_MASK && (done_q || master_fault_flag_q || ovr_q); // R1 R3
            WAKE_WAIT <= ctrl_q[`CTRL_IRQ_EN] && (done_q || master_fault_flag_q || ovr_q); // R2
            WAKE_HALT <= ctrl_q[`CTRL_IRQ_EN] && done_q; // R2
            SCK_O <= clock_idle_level ^ sck_int_q; // R6
            SCK_OE <= en && master; // R5
            MOSI_O <= shift_q[7];
            MOSI_OE <= drive_out && master; // R16
            MISO_O <= shift_q[7];
            MISO_OE <= drive_out && !master && !sel_b; // R16
        end
    end
endmodule
`default_nettype wire

// File: spi_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
    // serial pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_b,
    output logic miso,
    // byte to send, byte seen
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] shift_q;
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    // low idle clock, capture on first edge, same as the master setting
    always @(negedge sel_b) begin
        shift_q = tx_byte;
        miso = tx_byte[7];
    end
    always @(posedge sck) if (!sel_b) rx_byte = {rx_byte[6:0], mosi};
    always @(negedge sck) if (!sel_b) begin
        shift_q = {shift_q[6:0], 1'b0};
        miso = shift_q[7];
    end
    // released line must not keep showing the last bit
    always @(posedge sel_b) miso = ~miso;
endmodule
`default_nettype wire

// File: spi_ctrl_status_checker.sv
`timescale 1ns/10ps
`default_nettype none
module spi_ctrl_checker (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // events
    input wire logic IRQ_MASK,
    input wire logic IRQ,
    input wire logic WAKE_WAIT,
    input wire logic WAKE_HALT,
    // pins
    input wire logic SS_B_I,
    input wire logic SCK_OE,
    input wire logic MOSI_OE,
    input wire logic MISO_OE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    ready_after_access_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready missing");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready too long");
    slverr_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("slverr without ready");
    irq_mask_a: assert property (IRQ_MASK |=> !IRQ)
        else $error("irq while masked");
    irq_wake_a: assert property (IRQ |-> WAKE_WAIT)
        else $error("irq without event");
    halt_wait_a: assert property (WAKE_HALT |-> WAKE_WAIT)
        else $error("halt wake alone");
    oe_exclusive_a: assert property (!(MOSI_OE && MISO_OE))
        else $error("both data outputs on");
    mosi_master_a: assert property (MOSI_OE |-> SCK_OE)
        else $error("mosi out in slave");
    fault_drop_a: assert property ((!SS_B_I) [*8] |-> !SCK_OE)
        else $error("master kept on fault");
    reset_quiet_a: assert property ($past(!RST_B) |-> !IRQ && !SCK_OE && !MOSI_OE)
        else $error("outputs live after reset");
    cover property (IRQ);
    cover property (PSLVERR);
    cover property (WAKE_HALT);
    cover property ($fell(SCK_OE));
endmodule
bind spi_ctrl_status spi_ctrl_checker chk_u (.CORE_CLK, .RST_B, .PSEL, .PENABLE, .PREADY,
    .PSLVERR, .IRQ_MASK, .IRQ, .WAKE_WAIT, .WAKE_HALT, .SS_B_I, .SCK_OE, .MOSI_OE, .MISO_OE);
`default_nettype wire

// File: tb_spi_ctrl_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_ctrl_consts.vh"
module tb_spi_ctrl_status;
    logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, mask = 0, ss_b = 1, sel_b = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [7:0] tx_m, tx_s;
    logic err_b;
    wire [31:0] prdata;
    wire [7:0] rx_s;
    wire pready, pslverr, irq, ww, wh, sck, sck_oe, mosi, mosi_oe, miso, miso_o, miso_oe;
    int err_count = 0, check_count = 0;
    initial forever #5 clk = ~clk;
    spi_ctrl_status dut_u (.CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IRQ_MASK(mask), .IRQ(irq), .WAKE_WAIT(ww), .WAKE_HALT(wh),
        .SCK_I(1'b0), .SCK_O(sck), .SCK_OE(sck_oe), .MOSI_I(1'b0), .MOSI_O(mosi),
        .MOSI_OE(mosi_oe), .MISO_I(miso), .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_B_I(ss_b));
    spi_slave_model peer_u (.sck(sck), .mosi(mosi), .sel_b(sel_b), .miso(miso),
        .tx_byte(tx_s), .rx_byte(rx_s));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one apb transfer, request held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk(0, 1);
            give_verdict;
        end
        rd = prdata;
        err_b = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    initial begin
        int n;
        repeat (10) @(posedge clk);
        rst_b <= 1;
        void'($urandom(32'haaab));
        apb(0, `ADDR_CTRL, 0);
        chk(rd, 0);
        apb(0, `ADDR_CSR, 0);
        chk(rd, 0);
        apb(0, 12'h010, 0);
        chk(err_b, 1);
        // divide by 128 keeps the pin synchronisers well inside each half bit
        for (int i = 0; i < 4; i++) begin
            tx_m = $urandom;
            tx_s = (i == 0) ? 8'h80 : $urandom;
            mask <= i[0];
            sel_b <= 0;
            apb(1, `ADDR_CTRL, 8'hd3);
            apb(1, `ADDR_DATA, tx_m);
            apb(1, `ADDR_DATA, ~tx_m);
            for (n = 0; n < 3000 && ww !== 1'b1; n++) @(posedge clk);
            if (ww !== 1'b1) begin
                chk(0, 1);
                give_verdict;
            end
            chk(irq, !i[0]);
            chk(wh, 1);
            apb(0, `ADDR_CSR, 0);
            chk(rd, 32'hc0);
            chk(rx_s, tx_m);
            apb(0, `ADDR_DATA, 0);
            chk(rd, tx_s);
            apb(0, `ADDR_CSR, 0);
            chk(rd, 0);
            apb(1, `ADDR_CTRL, 8'h00);
            sel_b <= 1;
            repeat (2) @(posedge clk);
        end
        apb(1, `ADDR_CTRL, 8'h50);
        apb(1, `ADDR_CSR, 8'h04);
        repeat (2) @(posedge clk);
        chk(mosi_oe, 0);
        apb(1, `ADDR_CSR, 8'h00);
        repeat (2) @(posedge clk);
        chk(mosi_oe, 1);
        ss_b <= 0;
        repeat (12) @(posedge clk);
        apb(1, `ADDR_CTRL, 8'h50);
        apb(0, `ADDR_CTRL, 0);
        chk(rd, 0);
        apb(0, `ADDR_CSR, 0);
        chk(rd, 32'h10);
        ss_b <= 1;
        repeat (6) @(posedge clk);
        apb(1, `ADDR_CTRL, 8'h50);
        apb(0, `ADDR_CSR, 0);
        chk(rd, 0);
        apb(0, `ADDR_CTRL, 0);
        chk(rd, 32'h50);
        give_verdict;
    end
endmodule
`default_nettype wire
